// ==== verilog/srac_pkg.sv ====
// shared constants and carrier types for the spi register access and configuration block
package srac_pkg;

  // command bytes
  localparam logic [7:0] OPC_REG_READ   = 8'h8a;
  localparam logic [7:0] OPC_REG_WRITE  = 8'hcf;
  localparam logic [7:0] OPC_REG_STATUS = 8'had;
  localparam logic [7:0] OPC_ACTIVATE   = 8'hb0;
  localparam logic [7:0] OPC_SENS_DATA  = 8'ha6;
  localparam logic [7:0] OPC_SENS_STAT  = 8'hf5;

  // register addresses
  localparam logic [7:0] ADR_SIN_AMP   = 8'h00;
  localparam logic [7:0] ADR_COS_AMP   = 8'h01;
  localparam logic [7:0] ADR_PSIN_OFS  = 8'h02;
  localparam logic [7:0] ADR_NSIN_OFS  = 8'h03;
  localparam logic [7:0] ADR_PCOS_OFS  = 8'h04;
  localparam logic [7:0] ADR_NCOS_OFS  = 8'h05;
  localparam logic [7:0] ADR_LED_CTRL  = 8'h06;
  localparam logic [7:0] ADR_GAIN      = 8'h07;
  localparam logic [7:0] ADR_INTERP    = 8'h0e;
  localparam logic [7:0] ADR_INTERP_EN = 8'h11;
  localparam logic [7:0] ADR_STATE     = 8'h12;
  localparam logic [7:0] ADR_MISC      = 8'h13;

  // field positions
  localparam int POS_LED_STYLE  = 6;
  localparam int POS_LED_TYPE   = 6;
  localparam int POS_RES_LO     = 5;
  localparam int POS_INTERP_EN  = 4;
  localparam int POS_LED_ERR    = 7;
  localparam int POS_CODE_INV   = 0;

  // status byte bit positions
  localparam int ST_ERROR   = 7;
  localparam int ST_REFUSED = 3;
  localparam int ST_FAIL    = 2;
  localparam int ST_BUSY    = 1;
  localparam int ST_VALID   = 0;

  // reset values
  localparam logic [5:0] RST_AMP       = 6'h00;
  localparam logic [6:0] RST_OFS       = 7'h40;
  localparam logic [5:0] RST_SETPOINT  = 6'h20;
  localparam logic [1:0] RST_GAIN      = 2'h1;
  localparam logic [1:0] RST_RES       = 2'h0;
  localparam logic       RST_INTERP_EN = 1'b1;

  // interpolator resolution codes
  localparam logic [1:0] RES_8BIT = 2'h0;
  localparam logic [1:0] RES_7BIT = 2'h1;
  localparam logic [1:0] RES_6BIT = 2'h2;

  typedef struct packed {
    logic [5:0] sine_amplitude_trim;
    logic [5:0] cosine_amplitude_trim;
    logic       led_regulation_style;
    logic [6:0] pos_sine_offset_trim;
    logic [6:0] neg_sine_offset_trim;
    logic [6:0] pos_cosine_offset_trim;
    logic [6:0] neg_cosine_offset_trim;
    logic [5:0] led_setpoint;
    logic       led_regulation_type;
    logic [1:0] analog_gain_range;
    logic [1:0] interp_resolution;
    logic       interp_enable;
    logic       code_invert;
  } srac_cfg_type;

  typedef struct packed {
    logic error;
    logic refused;
    logic fail;
    logic busy;
    logic valid;
  } srac_status_type;

endpackage

// ==== verilog/srac_top.sv ====
// spi slave register access, configuration fields and digital alignment outputs
`timescale 1ns/1ns
// How it works
// - status bits refreshed on every register access
// - error bit reflects latest communication of any kind
// - status query: echo command, status, undefined byte
// - read: echo command and address, then data
// - read advances address after each data byte
// - read error freezes address, sets failure bit
// - write: echo command, address and data
// - write advances address after each data byte
// - write error freezes address, sets failure bit
// - two quadrature outputs, one period per turn
// - code inversion flips only the msb output
// - alignment output is xor of tracks four, ten, forced low in parallel mode
// - gain select at 0x07 bits 1:0
// - amplitude trims at 0x00 and 0x01 bits 5:0
// - four offset trims at 0x02 to 0x05
// - 0x06 bit 6 picks led control type
// - 0x06 bits 5:0 hold led setpoint
// - 0x01 bit 6 picks continuous or deadband
// - led range error flag ored with parity alarm
// - 0x0e bits 6:5 select interpolator resolution
// - disabled interpolator outputs zero position
// - decode 0x8a read, 0xcf write, 0xad status
// - status byte layout: error, refused, fail, busy, valid
// - channel off: error set, mosi passed through
// - sample on rising sck, msb first
module srac_top
  import srac_pkg::*;
(
  input  wire logic         i_mclk,
  input  wire logic         i_reset,
  input  wire logic         i_sck,
  input  wire logic         i_cs,
  input  wire logic         i_mosi,
  output logic              o_miso,
  input  wire logic         i_register_channel_on,
  input  wire logic         i_track_msb,
  input  wire logic         i_track_second,
  input  wire logic         i_code_invert_pin,
  input  wire logic         i_parallel_mode_select,
  input  wire logic         i_leading_track_four_diode,
  input  wire logic         i_track_ten_diode,
  input  wire logic         i_led_out_of_range,
  input  wire logic         i_parity_alarm,
  input  wire logic [7:0]   i_interp_position,
  output logic              o_quadrature_msb_out,
  output logic              o_quadrature_second_out,
  output logic              o_tilt_alignment_out,
  output logic              o_error_out,
  output logic [7:0]        o_interp_position,
  output srac_cfg_type      o_analog_cfg
);

  typedef enum logic [2:0] {
    FR_OPC   = 3'b000,
    FR_ADR   = 3'b001,
    FR_DATA  = 3'b011,
    FR_STAT  = 3'b010,
    FR_UNDEF = 3'b110,
    FR_IDLE  = 3'b100
  } srac_frame_type;

  typedef enum logic [1:0] {
    OP_NONE  = 2'b00,
    OP_READ  = 2'b01,
    OP_WRITE = 2'b11
  } srac_op_type;

  // read decode shared by the first data byte and every following one
  function automatic logic [8:0] reg_read(input srac_cfg_type c, input logic led_err, input logic [7:0] adr);
    logic [8:0] r;
    r = 9'h100;
    case (adr)
      ADR_SIN_AMP:   r = {3'h4, c.sine_amplitude_trim};
      ADR_COS_AMP:   r = {2'h2, c.led_regulation_style, c.cosine_amplitude_trim};
      ADR_PSIN_OFS:  r = {2'h2, c.pos_sine_offset_trim};
      ADR_NSIN_OFS:  r = {2'h2, c.neg_sine_offset_trim};
      ADR_PCOS_OFS:  r = {2'h2, c.pos_cosine_offset_trim};
      ADR_NCOS_OFS:  r = {2'h2, c.neg_cosine_offset_trim};
      ADR_LED_CTRL:  r = {2'h2, c.led_regulation_type, c.led_setpoint};
      ADR_GAIN:      r = {7'h40, c.analog_gain_range};
      ADR_INTERP:    r = {2'h2, c.interp_resolution, 5'h00};
      ADR_INTERP_EN: r = {4'h8, c.interp_enable, 4'h0};
      ADR_STATE:     r = {1'b1, led_err, 7'h00};
      ADR_MISC:      r = {8'h80, c.code_invert};
      default:       r = 9'h000;
    endcase
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // sck domain: reset and led flag synchronisers

  logic rst_meta_ff;
  logic rst_sync_ff;
  logic led_meta_ff;
  logic led_sync_ff;
  logic led_err_ff;

  // the reset only lands while sck runs, so hold it across a few sck edges
  always_ff @(posedge i_sck) begin
    rst_meta_ff <= i_reset;
    rst_sync_ff <= rst_meta_ff;
    led_meta_ff <= led_err_ff;
    led_sync_ff <= led_meta_ff;
  end

  //////////////////////////////////////////////////////////////////////////////
  // sck domain: frame state, cleared whenever chip select drops

  srac_frame_type  frame_ff;
  srac_frame_type  nxt_frame;
  srac_op_type     op_ff;
  srac_op_type     nxt_op;
  logic [2:0]      bit_cnt_ff;
  logic [2:0]      nxt_bit_cnt;
  logic [6:0]      rx_ff;
  logic [6:0]      nxt_rx;
  logic [7:0]      adr_ff;
  logic [7:0]      nxt_adr;
  logic [7:0]      tx_ff;
  logic [7:0]      nxt_tx;
  logic            pass_ff;
  logic            nxt_pass;
  srac_cfg_type    cfg_ff;
  srac_cfg_type    nxt_cfg;
  srac_status_type stat_ff;
  srac_status_type nxt_stat;

  logic [7:0] rx_byte;
  logic [8:0] rd_now;
  logic [8:0] rd_next;
  logic [8:0] rd_cur;
  logic [7:0] adr_inc;

  assign rx_byte = {rx_ff, i_mosi};
  assign adr_inc = adr_ff + 8'h01;
  assign rd_now  = reg_read(cfg_ff, led_sync_ff, rx_byte);
  assign rd_next = reg_read(cfg_ff, led_sync_ff, adr_inc);
  assign rd_cur  = reg_read(cfg_ff, led_sync_ff, adr_ff);

  // byte assembly on every rising edge; command sequencing acts on the eighth rising edge
  always_comb begin
    nxt_frame   = frame_ff;
    nxt_op      = op_ff;
    nxt_bit_cnt = bit_cnt_ff + 3'h1;
    nxt_rx      = {rx_ff[5:0], i_mosi};
    nxt_adr     = adr_ff;
    nxt_tx      = tx_ff;
    nxt_pass    = pass_ff;
    nxt_cfg     = cfg_ff;
    nxt_stat    = stat_ff;
    if (bit_cnt_ff == 3'h7) begin
      case (frame_ff)
        FR_OPC: begin
          nxt_pass  = 1'b1;
          nxt_frame = FR_IDLE;
          nxt_stat.error = 1'b0;
          if (rx_byte == OPC_REG_READ || rx_byte == OPC_REG_WRITE || rx_byte == OPC_REG_STATUS) begin
            if (!i_register_channel_on) begin
              nxt_stat.error = 1'b1;
            end else if (rx_byte == OPC_REG_STATUS) begin
              nxt_frame = FR_STAT;
              nxt_pass  = 1'b0;
              nxt_tx    = {stat_ff.error, 3'h0, stat_ff.refused, stat_ff.fail, stat_ff.busy, stat_ff.valid};
            end else begin
              nxt_frame = FR_ADR;
              nxt_op    = (rx_byte == OPC_REG_READ) ? OP_READ : OP_WRITE;
              nxt_stat  = '0;
            end
          end else if (rx_byte != OPC_ACTIVATE && rx_byte != OPC_SENS_DATA && rx_byte != OPC_SENS_STAT) begin
            nxt_stat.error = 1'b1;
          end
        end
        FR_ADR: begin
          nxt_adr   = rx_byte;
          nxt_frame = FR_DATA;
          if (op_ff == OP_READ) begin
            nxt_pass = 1'b0;
            nxt_tx   = rd_now[7:0];
            if (!rd_now[8]) begin
              nxt_stat.fail    = 1'b1;
              nxt_stat.refused = 1'b1;
            end
          end
        end
        FR_DATA: begin
          if (op_ff == OP_READ) begin
            // a byte fails only once it was clocked out, so a prefetch past the map stays harmless
            if (!stat_ff.fail && rd_cur[8]) begin
              nxt_stat.valid = 1'b1;
              nxt_adr        = adr_inc;
              nxt_tx         = rd_next[7:0];
            end else begin
              nxt_stat.fail    = 1'b1;
              nxt_stat.refused = 1'b1;
              nxt_tx           = 8'h00;
            end
          end else if (!stat_ff.fail && rd_cur[8] && adr_ff != ADR_STATE) begin
            nxt_stat.valid = 1'b1;
            nxt_adr        = adr_inc;
            case (adr_ff)
              ADR_SIN_AMP:   nxt_cfg.sine_amplitude_trim = rx_byte[5:0];
              ADR_COS_AMP: begin
                nxt_cfg.cosine_amplitude_trim = rx_byte[5:0];
                nxt_cfg.led_regulation_style  = rx_byte[POS_LED_STYLE];
              end
              ADR_PSIN_OFS:  nxt_cfg.pos_sine_offset_trim   = rx_byte[6:0];
              ADR_NSIN_OFS:  nxt_cfg.neg_sine_offset_trim   = rx_byte[6:0];
              ADR_PCOS_OFS:  nxt_cfg.pos_cosine_offset_trim = rx_byte[6:0];
              ADR_NCOS_OFS:  nxt_cfg.neg_cosine_offset_trim = rx_byte[6:0];
              ADR_LED_CTRL: begin
                nxt_cfg.led_setpoint        = rx_byte[5:0];
                nxt_cfg.led_regulation_type = rx_byte[POS_LED_TYPE];
              end
              ADR_GAIN:      nxt_cfg.analog_gain_range = rx_byte[1:0];
              ADR_INTERP:    nxt_cfg.interp_resolution = rx_byte[POS_RES_LO+1:POS_RES_LO];
              ADR_INTERP_EN: nxt_cfg.interp_enable     = rx_byte[POS_INTERP_EN];
              default:       nxt_cfg.code_invert       = rx_byte[POS_CODE_INV];
            endcase
          end else begin
            nxt_stat.fail    = 1'b1;
            nxt_stat.refused = 1'b1;
          end
        end
        FR_STAT: begin
          nxt_frame = FR_UNDEF;
          nxt_tx    = 8'h00;
        end
        FR_UNDEF: begin
          nxt_frame = FR_IDLE;
          nxt_pass  = 1'b1;
        end
        default: begin
          nxt_frame = FR_IDLE;
        end
      endcase
    end
  end

  // frame registers; chip select low is the only thing that ends a frame, since sck stops between frames
  always_ff @(posedge i_sck or negedge i_cs) begin
    if (!i_cs) begin
      frame_ff   <= FR_OPC;
      op_ff      <= OP_NONE;
      bit_cnt_ff <= 3'h0;
      rx_ff      <= 7'h00;
      adr_ff     <= 8'h00;
      tx_ff      <= 8'hff;
      pass_ff    <= 1'b1;
    end else begin
      frame_ff   <= nxt_frame;
      op_ff      <= nxt_op;
      bit_cnt_ff <= nxt_bit_cnt;
      rx_ff      <= nxt_rx;
      adr_ff     <= nxt_adr;
      tx_ff      <= nxt_tx;
      pass_ff    <= nxt_pass;
    end
  end

  // configuration and status persist across frames
  always_ff @(posedge i_sck) begin
    if (rst_sync_ff) begin
      cfg_ff.sine_amplitude_trim    <= RST_AMP;
      cfg_ff.cosine_amplitude_trim  <= RST_AMP;
      cfg_ff.led_regulation_style   <= 1'b0;
      cfg_ff.pos_sine_offset_trim   <= RST_OFS;
      cfg_ff.neg_sine_offset_trim   <= RST_OFS;
      cfg_ff.pos_cosine_offset_trim <= RST_OFS;
      cfg_ff.neg_cosine_offset_trim <= RST_OFS;
      cfg_ff.led_setpoint           <= RST_SETPOINT;
      cfg_ff.led_regulation_type    <= 1'b0;
      cfg_ff.analog_gain_range      <= RST_GAIN;
      cfg_ff.interp_resolution      <= RST_RES;
      cfg_ff.interp_enable          <= RST_INTERP_EN;
      cfg_ff.code_invert            <= 1'b0;
      stat_ff                       <= '0;
    end else begin
      cfg_ff  <= nxt_cfg;
      stat_ff <= nxt_stat;
    end
  end

  // idle high outside a frame; echoed bytes follow mosi with no delay
  assign o_miso       = !i_cs ? 1'b1 : (pass_ff ? i_mosi : tx_ff[3'h7 - bit_cnt_ff]);
  assign o_analog_cfg = cfg_ff;

  //////////////////////////////////////////////////////////////////////////////
  // mclk domain: level synchronisers for pins and configuration bits

  localparam int SYNC_W = 9;

  logic [SYNC_W-1:0] sync_in;
  logic [SYNC_W-1:0] sync_meta_ff;
  logic [SYNC_W-1:0] sync_ff;

  // resolution bits could tear for a cycle; harmless because the enable is cleared around a change
  assign sync_in = {cfg_ff.code_invert, cfg_ff.interp_enable, cfg_ff.interp_resolution,
                    i_code_invert_pin, i_parallel_mode_select, i_leading_track_four_diode,
                    i_track_ten_diode, i_led_out_of_range};

  always_ff @(posedge i_mclk) begin
    sync_meta_ff <= sync_in;
    sync_ff      <= sync_meta_ff;
  end

  logic       s_code_inv_reg;
  logic       s_interp_en;
  logic [1:0] s_interp_res;
  logic       s_code_inv_pin;
  logic       s_par_mode;
  logic       s_track_four;
  logic       s_track_ten;
  logic       s_led_oor;

  assign {s_code_inv_reg, s_interp_en, s_interp_res, s_code_inv_pin,
          s_par_mode, s_track_four, s_track_ten, s_led_oor} = sync_ff;

  //////////////////////////////////////////////////////////////////////////////
  // mclk domain: output stage

  logic       quad_msb_ff;
  logic       nxt_quad_msb;
  logic       quad_sec_ff;
  logic       nxt_quad_sec;
  logic       tilt_ff;
  logic       nxt_tilt;
  logic       err_out_ff;
  logic       nxt_err_out;
  logic [7:0] ipos_ff;
  logic [7:0] nxt_ipos;
  logic       nxt_led_err;

  // quadrature outputs taken from the track msbs, so counter resolution and zero offset never reach them
  always_comb begin
    nxt_quad_msb = i_track_msb ^ (s_code_inv_pin | s_code_inv_reg);
    nxt_quad_sec = i_track_second;
    nxt_tilt     = !s_par_mode & (s_track_four ^ s_track_ten);
    nxt_led_err  = s_led_oor;
    nxt_err_out  = led_err_ff | i_parity_alarm;
    case (s_interp_res)
      RES_8BIT: nxt_ipos = i_interp_position;
      RES_7BIT: nxt_ipos = {i_interp_position[7:1], 1'b0};
      RES_6BIT: nxt_ipos = {i_interp_position[7:2], 2'h0};
      default:  nxt_ipos = 8'h00;
    endcase
    if (!s_interp_en) begin
      nxt_ipos = 8'h00;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      quad_msb_ff <= 1'b0;
      quad_sec_ff <= 1'b0;
      tilt_ff     <= 1'b0;
      led_err_ff  <= 1'b0;
      err_out_ff  <= 1'b0;
      ipos_ff     <= 8'h00;
    end else begin
      quad_msb_ff <= nxt_quad_msb;
      quad_sec_ff <= nxt_quad_sec;
      tilt_ff     <= nxt_tilt;
      led_err_ff  <= nxt_led_err;
      err_out_ff  <= nxt_err_out;
      ipos_ff     <= nxt_ipos;
    end
  end

  assign o_quadrature_msb_out    = quad_msb_ff;
  assign o_quadrature_second_out = quad_sec_ff;
  assign o_tilt_alignment_out    = tilt_ff;
  assign o_error_out             = err_out_ff;
  assign o_interp_position       = ipos_ff;

endmodule

// ==== tb/srac_top_asserts.sv ====
// concurrent checks on the pins of the spi configuration block
`timescale 1ns/1ns
module srac_top_asserts
  import srac_pkg::*;
(
  input wire logic         i_mclk,
  input wire logic         i_reset,
  input wire logic         i_sck,
  input wire logic         i_cs,
  input wire logic         i_mosi,
  input wire logic         o_miso,
  input wire logic         i_track_msb,
  input wire logic         i_track_second,
  input wire logic         i_code_invert_pin,
  input wire logic         i_parallel_mode_select,
  input wire logic         i_leading_track_four_diode,
  input wire logic         i_track_ten_diode,
  input wire logic         i_led_out_of_range,
  input wire logic         i_parity_alarm,
  input wire logic [7:0]   i_interp_position,
  input wire logic         o_quadrature_msb_out,
  input wire logic         o_quadrature_second_out,
  input wire logic         o_tilt_alignment_out,
  input wire logic         o_error_out,
  input wire logic [7:0]   o_interp_position,
  input wire srac_cfg_type o_analog_cfg
);
  ////////////////////////////////////////////////////////////
  // synced levels need three cycles, the led flag four, so a level is judged only after four quiet ones
  logic [9:0] snap;
  logic [9:0] snap_ff;
  logic [3:0] calm_ff;
  logic       calm;
  logic       en;
  logic [1:0] res;
  assign en   = o_analog_cfg.interp_enable;
  assign res  = o_analog_cfg.interp_resolution;
  assign snap = {i_code_invert_pin, i_parallel_mode_select, i_leading_track_four_diode, i_track_ten_diode,
                 i_led_out_of_range, o_analog_cfg.code_invert, en, res, i_reset};
  assign calm = (calm_ff >= 4'h4) && (snap == snap_ff);
  always_ff @(posedge i_mclk) begin
    snap_ff <= snap;
    if (i_reset || (snap != snap_ff)) begin
      calm_ff <= 4'h0;
    end else if (calm_ff != 4'hf) begin
      calm_ff <= calm_ff + 4'h1;
    end
  end
  // bit count and opcode of the current frame, cleared while not selected
  logic [7:0] bits_ff;
  logic [7:0] op_ff;
  always_ff @(posedge i_sck or negedge i_cs) begin
    if (!i_cs) begin
      bits_ff <= 8'h00;
      op_ff   <= 8'h00;
    end else begin
      if (bits_ff != 8'hff) bits_ff <= bits_ff + 8'h01;
      if (bits_ff < 8'h08) op_ff <= {op_ff[6:0], i_mosi};
    end
  end
  ////////////////////////////////////////////////////////////
  sequence s_head;
    (bits_ff < 8'h08) || (op_ff == OPC_REG_READ && bits_ff < 8'h10);
  endsequence
  sequence s_write_body;
    op_ff == OPC_REG_WRITE && bits_ff >= 8'h08;
  endsequence
  a_echo_head: assert property (@(posedge i_sck) disable iff (!i_cs || i_reset)
    s_head |-> o_miso == i_mosi) else $error("opcode or address not echoed");
  a_echo_write: assert property (@(posedge i_sck) disable iff (!i_cs || i_reset)
    s_write_body |-> o_miso == i_mosi) else $error("write data not echoed");
  a_miso_idle: assert property (@(posedge i_mclk) disable iff (i_reset)
    (!i_cs) [*2] |-> o_miso) else $error("miso not high between frames");
  a_quad_msb: assert property (@(posedge i_mclk) disable iff (i_reset)
    calm |-> o_quadrature_msb_out == ($past(i_track_msb) ^ (i_code_invert_pin | o_analog_cfg.code_invert)))
    else $error("msb quadrature output wrong");
  a_quad_second: assert property (@(posedge i_mclk) disable iff (i_reset)
    calm |-> o_quadrature_second_out == $past(i_track_second)) else $error("second quadrature output wrong");
  a_tilt_xor: assert property (@(posedge i_mclk) disable iff (i_reset)
    calm |-> o_tilt_alignment_out == (!i_parallel_mode_select && (i_leading_track_four_diode ^ i_track_ten_diode)))
    else $error("alignment output wrong");
  a_error_merge: assert property (@(posedge i_mclk) disable iff (i_reset)
    calm |-> o_error_out == ($past(i_parity_alarm) | i_led_out_of_range)) else $error("error output wrong");
  a_interp_zero: assert property (@(posedge i_mclk) disable iff (i_reset)
    calm && (!en || res == 2'h3) |-> o_interp_position == 8'h00) else $error("idle interpolator not zero");
  a_interp_pass: assert property (@(posedge i_mclk) disable iff (i_reset)
    calm && en && res == RES_8BIT |-> o_interp_position == $past(i_interp_position))
    else $error("full resolution position wrong");
endmodule
bind srac_top srac_top_asserts srac_top_asserts_inst (.i_mclk, .i_reset, .i_sck, .i_cs, .i_mosi, .o_miso,
  .i_track_msb, .i_track_second, .i_code_invert_pin, .i_parallel_mode_select, .i_leading_track_four_diode,
  .i_track_ten_diode, .i_led_out_of_range, .i_parity_alarm, .i_interp_position, .o_quadrature_msb_out,
  .o_quadrature_second_out, .o_tilt_alignment_out, .o_error_out, .o_interp_position, .o_analog_cfg);

// ==== tb/srac_master.sv ====
// spi master model that frames register traffic toward the configuration block
`timescale 1ns/1ns
module srac_master (
  output logic      o_sck,
  output logic      o_cs,
  output logic      o_mosi,
  input  wire logic i_miso
);
  // sck idles low and runs only on request
  initial begin
    o_sck  = 1'b0;
    o_cs   = 1'b0;
    o_mosi = 1'b1;
  end
  // clocks with no frame, only to carry reset into the link domain
  task automatic idle_clocks(input int n);
    repeat (n) begin
      #62 o_sck = 1'b1;
      #63 o_sck = 1'b0;
    end
  endtask
  // whole bytes msb first; miso taken just before each rising edge, gap stalls between bytes
  task automatic frame(input logic [7:0] tx[$], output logic [7:0] rx[$], input int gap);
    logic [7:0] b;
    rx = {};
    #37 o_cs = 1'b1;
    foreach (tx[i]) begin
      for (int k = 7; k >= 0; k--) begin
        o_mosi = tx[i][k];
        #62 b[k] = i_miso;
        o_sck = 1'b1;
        #63 o_sck = 1'b0;
      end
      rx.push_back(b);
      #(gap);
    end
    #37 o_cs = 1'b0;
    o_mosi = ~o_mosi; // a released line must not keep a believable level
  endtask
endmodule

// ==== tb/test_srac_top.sv ====
// self-checking bench for the spi configuration block
`timescale 1ns/1ns
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_srac_top
  import srac_pkg::*;
;
  logic         i_mclk, i_reset, sck, cs, mosi, miso, chan_on;
  logic         trk_msb, trk_sec, inv_pin, pms, four, ten, led_bad, parity;
  logic         q_msb, q_sec, tilt, err_out;
  logic [7:0]   ipos, opos;
  srac_cfg_type cfg;
  logic [7:0]   rx[$];
  int           fail_count, checks_done, cyc, gap;

  srac_top srac_top_inst (.i_mclk(i_mclk), .i_reset(i_reset), .i_sck(sck), .i_cs(cs), .i_mosi(mosi),
    .o_miso(miso), .i_register_channel_on(chan_on), .i_track_msb(trk_msb), .i_track_second(trk_sec),
    .i_code_invert_pin(inv_pin), .i_parallel_mode_select(pms), .i_leading_track_four_diode(four),
    .i_track_ten_diode(ten), .i_led_out_of_range(led_bad), .i_parity_alarm(parity),
    .i_interp_position(ipos), .o_quadrature_msb_out(q_msb), .o_quadrature_second_out(q_sec),
    .o_tilt_alignment_out(tilt), .o_error_out(err_out), .o_interp_position(opos), .o_analog_cfg(cfg));
  srac_master srac_master_inst (.o_sck(sck), .o_cs(cs), .o_mosi(mosi), .i_miso(miso));

  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  // a hang is cut short well past the expected run length
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 50000) begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (fail_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] adr, input logic [7:0] d[$]);
    logic [7:0] tx[$];
    tx = {OPC_REG_WRITE, adr, d};
    srac_master_inst.frame(tx, rx, gap);
    foreach (tx[i]) `CHK(rx[i], tx[i])
  endtask
  task automatic rd(input logic [7:0] adr, input logic [7:0] exp[$]);
    logic [7:0] tx[$];
    tx = {OPC_REG_READ, adr};
    foreach (exp[i]) tx.push_back(8'h00);
    srac_master_inst.frame(tx, rx, gap);
    `CHK({rx[0], rx[1]}, {OPC_REG_READ, adr})
    foreach (exp[i]) `CHK(rx[i + 2], exp[i])
  endtask
  task automatic st(input logic [7:0] mask, input logic [7:0] exp);
    logic [7:0] tx[$];
    tx = {OPC_REG_STATUS, 8'h00, 8'h00};
    srac_master_inst.frame(tx, rx, gap);
    `CHK(rx[0], OPC_REG_STATUS)
    `CHK(rx[1] & mask, exp)
  endtask
  task automatic settle();
    repeat (6) @(posedge i_mclk);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    {i_reset, chan_on} = 2'h3;
    {trk_msb, trk_sec, inv_pin, pms, four, ten, led_bad, parity} = 8'h00;
    ipos = 8'h00;
    {fail_count, checks_done, cyc} = '0;
    gap = 900;
    // the link domain needs several sck edges while reset is high
    fork
      repeat (12) @(posedge i_mclk);
      srac_master_inst.idle_clocks(4);
    join
    @(posedge i_mclk) i_reset <= 1'b0;
    srac_master_inst.idle_clocks(3);
    // reset values through one slow continuous read
    rd(ADR_SIN_AMP, {8'h00, 8'h00, 8'h40, 8'h40, 8'h40, 8'h40, 8'h20, 8'h01});
    st(8'hff, 8'h01);
    gap = 0;
    // the test mux sits outside this block, so trims are written as a calibrating master would
    wr(ADR_SIN_AMP, {8'hff, 8'hff, 8'h7f, 8'h80, 8'h55, 8'h2a, 8'hff, 8'h03});
    rd(ADR_SIN_AMP, {8'h3f, 8'h7f, 8'h7f, 8'h00, 8'h55, 8'h2a, 8'h7f, 8'h03});
    `CHK(cfg, {6'h3f, 6'h3f, 1'b1, 7'h7f, 7'h00, 7'h55, 7'h2a, 6'h3f, 1'b1, 2'h3, 2'h0, 1'b1, 1'b0})
    for (int g = 0; g < 4; g++) begin
      wr(ADR_GAIN, {8'(g)});
      `CHK(cfg.analog_gain_range, 2'(g))
    end
    // interpolator: resolution only changed while disabled
    @(posedge i_mclk) ipos <= 8'ha7;
    wr(ADR_INTERP_EN, {8'h00});
    settle();
    `CHK(opos, 8'h00)
    for (int r = 2; r >= 0; r--) begin
      wr(ADR_INTERP_EN, {8'h00});
      wr(ADR_INTERP, {8'(r << 5)});
      `CHK(cfg.interp_resolution, 2'(r))
      wr(ADR_INTERP_EN, {8'h10});
      settle();
      `CHK(opos, 8'ha7 & (8'hff << r))
    end
    // failures freeze the address counter
    wr(ADR_GAIN, {8'h02, 8'h55});
    `CHK(cfg.analog_gain_range, 2'h2)
    st(8'h84, 8'h04);
    wr(8'h0d, {8'h20, 8'h20});
    `CHK(cfg.interp_resolution, RES_8BIT)
    rd(8'h10, {8'h00, 8'h00});
    st(8'h8c, 8'h0c);
    wr(ADR_GAIN, {8'h01});
    st(8'h0f, 8'h01);
    // channel off and foreign opcodes report through the error bit
    @(posedge i_mclk) chan_on <= 1'b0;
    srac_master_inst.frame({OPC_REG_READ, 8'h00, 8'h5a}, rx, 0);
    `CHK({rx[0], rx[1], rx[2]}, {OPC_REG_READ, 8'h00, 8'h5a})
    @(posedge i_mclk) chan_on <= 1'b1;
    st(8'h80, 8'h80);
    srac_master_inst.frame({8'h55, 8'h33}, rx, 0);
    `CHK(rx[1], 8'h33)
    st(8'h80, 8'h80);
    srac_master_inst.frame({OPC_ACTIVATE, 8'h33}, rx, 0);
    st(8'h80, 8'h00);
    // pin paths over eight input patterns
    for (int i = 0; i < 8; i++) begin
      @(posedge i_mclk) {trk_msb, trk_sec, inv_pin, pms, four, ten, led_bad, parity} <= {3'(i), 3'(i), 2'(i)};
      settle();
      `CHK(q_msb, trk_msb ^ inv_pin)
      `CHK(q_sec, trk_sec)
      `CHK(tilt, !pms & (four ^ ten))
      `CHK(err_out, led_bad | parity)
    end
    @(posedge i_mclk) {trk_msb, trk_sec, inv_pin, parity} <= 4'h0;
    wr(ADR_MISC, {8'h01});
    settle();
    `CHK({q_msb, q_sec}, 2'h2)
    rd(ADR_STATE, {8'h80});
    report_and_stop();
  end
endmodule
